/* File: design/wkr_pkg.sv */
// Purpose: Shared constants of the wakeup receiver register bank
// Assumes: Word registers on a byte-addressed bus, index = adr[7:2]
// Notes:   Offsets are register indices; byte address is four times
package wkr_pkg;
   // ****************************************
   // Register indices
   // ****************************************
   localparam logic [5:0] IDX_PCTL = 6'h20;
   localparam logic [5:0] IDX_AZC  = 6'h21;
   localparam logic [5:0] IDX_STAT = 6'h24;
   localparam logic [5:0] IDX_RXB  = 6'h25;
   localparam logic [5:0] IDX_IDL  = 6'h26;
   localparam logic [5:0] IDX_IDH  = 6'h27;
   localparam logic [5:0] IDX_EVS  = 6'h28;
   localparam logic [5:0] IDX_EVC  = 6'h29;
   localparam logic [5:0] IDX_EVE  = 6'h2A;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PCTL_PAGE  = 0;
   localparam int PCTL_MODE  = 1;
   localparam int PCTL_DMODE = 3;
   localparam int PCTL_DRIE  = 4;
   localparam int STAT_RDY   = 7;
   localparam int STAT_IDF   = 4;
   localparam int STAT_OVF   = 3;
   localparam int STAT_FCLR  = 0;
   localparam int EV_BYTE    = 0;
   localparam int EV_IDOK    = 1;
   localparam int EV_DROP    = 2;

   // ****************************************
   // Match modes and reset values
   // ****************************************
   localparam logic [1:0] MM_OFF  = 2'h0;
   localparam logic [1:0] MM_LOW  = 2'h1;
   localparam logic [1:0] MM_HIGH = 2'h2;
   localparam logic [1:0] MM_BOTH = 2'h3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_AZC  = 3'h0;
   localparam logic [2:0] RST_EV   = 3'h0;
endpackage : wkr_pkg

/* File: design/wkr_asm_if.sv */
// Purpose: Bit stream in, assembled byte out
// Assumes: One clock domain
// Notes:   done is a one-cycle pulse with byte_val valid
`timescale 1ns/1ps
interface wkr_asm_if;
   logic       bit_valid;
   logic       bit_val;
   logic       clear;
   logic [7:0] byte_val;
   logic       done;

   modport asm_side (input bit_valid, bit_val, clear,
                     output byte_val, done);
   modport ctl_side (output bit_valid, bit_val, clear,
                     input byte_val, done);
endinterface : wkr_asm_if

/* File: design/wkr_byte_asm.sv */
// Purpose: Serial to byte assembler, first bit lands in bit 7
// Assumes: Bits arrive as single-cycle strobes
// Notes:   clear drops a partial byte at message start
`timescale 1ns/1ps
module wkr_byte_asm (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Stream
   wkr_asm_if.asm_side a
);
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
      logic [7:0] byte_val;
      logic       done;
   } wkr_asm_s;

   wkr_asm_s st;
   wkr_asm_s next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'h0;
      if (a.clear) begin
         next_st.cnt = 3'h0;
      end else if (a.bit_valid) begin
         next_st.sh  = {st.sh[6:0], a.bit_val};
         next_st.cnt = st.cnt + 3'h1;
         if (st.cnt == 3'h7) begin
            next_st.byte_val = {st.sh[6:0], a.bit_val};
            next_st.done     = 1'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign a.byte_val = st.byte_val;
   assign a.done     = st.done;
endmodule : wkr_byte_asm

/* File: design/wkr_regs.sv */
// Purpose: Wakeup receiver data, ID and autozero register bank
// Assumes: Classic Wishbone slave, one wait state, 8-bit registers
// Notes:   Receiver bits arrive already decoded, one per strobe
`timescale 1ns/1ps
module wkr_regs (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Decoded receiver stream
   input  wire logic        rx_bit_i,
   input  wire logic        rx_bit_valid_i,
   input  wire logic        rx_msg_start_i,
   // Outputs to system and analog
   output logic             irq_o,
   output logic             wake_o,
   output logic      [1:0]  az_seq_o,
   output logic             az_trim_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        page;
      logic [1:0]  mode;
      logic        dmode;
      logic        drie;
      logic [2:0]  azc;
      logic [7:0]  rx_byte;
      logic [7:0]  id_lo;
      logic [7:0]  id_hi;
      logic [7:0]  rx_hi;
      logic        rdy;
      logic        ovf;
      logic        idf;
      logic [1:0]  bcnt;
      logic        drop;
      logic [2:0]  evs;
      logic [2:0]  eve;
      logic        irq;
      logic        wake;
   } wkr_regs_s;

   wkr_regs_s   st;
   wkr_regs_s   next_st;
   logic        acc;
   logic        wr;
   logic        rd;
   logic [5:0]  idx;
   logic        rd_clr;
   logic        fclr;
   logic        load;
   logic        id_ok;
   logic        id_bad;
   logic        pg_hit;

   wkr_asm_if asm_bus ();

   // Compare only the bytes that the mode selects
   function automatic logic id_match(input logic [1:0] mode,
                                     input logic [7:0] hi_rx,
                                     input logic [7:0] lo_rx,
                                     input logic [7:0] hi_ref,
                                     input logic [7:0] lo_ref);
      logic hi_eq;
      logic lo_eq;
      hi_eq = (hi_rx == hi_ref);
      lo_eq = (lo_rx == lo_ref);
      case (mode)
         wkr_pkg::MM_LOW:  id_match = lo_eq;
         wkr_pkg::MM_HIGH: id_match = hi_eq;
         wkr_pkg::MM_BOTH: id_match = hi_eq && lo_eq;
         default:          id_match = 1'h1;
      endcase
   endfunction : id_match

   // ****************************************
   // Byte assembler
   // ****************************************
   assign asm_bus.bit_valid = rx_bit_valid_i && st.dmode;
   assign asm_bus.bit_val   = rx_bit_i;
   assign asm_bus.clear     = rx_msg_start_i;

   wkr_byte_asm u_asm (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .a     (asm_bus.asm_side)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;
      acc     = cyc_i && stb_i && !st.ack;
      idx     = adr_i[7:2];
      wr      = acc && we_i && sel_i[0];
      rd      = acc && !we_i;
      pg_hit  = (idx >= wkr_pkg::IDX_STAT) && (idx <= wkr_pkg::IDX_IDH);
      rd_clr  = rd && !st.page && idx == wkr_pkg::IDX_RXB;
      fclr    = wr && !st.page && idx == wkr_pkg::IDX_STAT
                && dat_i[wkr_pkg::STAT_FCLR];
      load    = 1'h0;
      id_ok   = 1'h0;
      id_bad  = 1'h0;
      next_st.ack  = acc;
      next_st.wake = 1'h0;
      next_st.dat  = 32'h0000_0000;

      // Reads; page one hides the page-zero registers
      if (rd && !(st.page && pg_hit)) begin
         case (idx)
            wkr_pkg::IDX_PCTL: next_st.dat[4:0] =
               {st.drie, st.dmode, st.mode, st.page};
            wkr_pkg::IDX_AZC:  next_st.dat[2:0] = st.azc;
            wkr_pkg::IDX_STAT: next_st.dat[7:0] =
               {st.rdy, 2'h0, st.idf, st.ovf, 3'h0};
            wkr_pkg::IDX_RXB:  next_st.dat[7:0] = st.rx_byte;
            wkr_pkg::IDX_IDL:  next_st.dat[7:0] = st.id_lo;
            wkr_pkg::IDX_IDH:  next_st.dat[7:0] = st.id_hi;
            wkr_pkg::IDX_EVS:  next_st.dat[2:0] = st.evs;
            wkr_pkg::IDX_EVE:  next_st.dat[2:0] = st.eve;
            default:           next_st.dat = 32'h0000_0000;
         endcase
      end

      // Writes; the received byte index has no write path
      if (wr && !(st.page && pg_hit)) begin
         case (idx)
            wkr_pkg::IDX_PCTL: begin
               next_st.page  = dat_i[wkr_pkg::PCTL_PAGE];
               next_st.mode  = dat_i[wkr_pkg::PCTL_MODE +: 2];
               next_st.dmode = dat_i[wkr_pkg::PCTL_DMODE];
               next_st.drie  = dat_i[wkr_pkg::PCTL_DRIE];
            end
            wkr_pkg::IDX_AZC: next_st.azc   = dat_i[2:0];
            wkr_pkg::IDX_IDL: next_st.id_lo = dat_i[7:0];
            wkr_pkg::IDX_IDH: next_st.id_hi = dat_i[7:0];
            wkr_pkg::IDX_EVC: next_st.evs   = st.evs & ~dat_i[2:0];
            wkr_pkg::IDX_EVE: next_st.eve   = dat_i[2:0];
            default: ;
         endcase
      end

      // Flag clears come first so a new event below wins
      if (rd_clr) begin
         next_st.rdy = 1'h0;
      end
      if (fclr) begin
         next_st.rdy = 1'h0;
         next_st.ovf = 1'h0;
         next_st.idf = 1'h0;
      end

      // Message framing: first two bytes carry the ID when matching
      if (asm_bus.done && st.dmode) begin
         if (st.mode == wkr_pkg::MM_OFF || st.bcnt == 2'h2) begin
            load = !st.drop;
            if (st.bcnt != 2'h2) begin
               next_st.wake = 1'h1;
               next_st.bcnt = 2'h2;
            end
         end else if (st.bcnt == 2'h0) begin
            next_st.rx_hi = asm_bus.byte_val;
            next_st.bcnt  = 2'h1;
         end else begin
            next_st.bcnt = 2'h2;
            if (id_match(st.mode, st.rx_hi, asm_bus.byte_val,
                         st.id_hi, st.id_lo)) begin
               id_ok = 1'h1;
            end else begin
               id_bad = 1'h1;
            end
         end
      end

      if (id_ok) begin
         next_st.idf             = 1'h1;
         next_st.wake            = 1'h1;
         next_st.evs[wkr_pkg::EV_IDOK] = 1'h1;
      end
      if (id_bad) begin
         next_st.drop            = 1'h1;
         next_st.evs[wkr_pkg::EV_DROP] = 1'h1;
      end

      if (load) begin
         next_st.rx_byte = asm_bus.byte_val;
         next_st.rdy     = 1'h1;
         if (st.rdy && !rd_clr) begin
            next_st.ovf = 1'h1;
         end
         next_st.evs[wkr_pkg::EV_BYTE] = 1'h1;
      end

      // A new message starts with a fresh ID check
      if (rx_msg_start_i) begin
         next_st.bcnt = 2'h0;
         next_st.drop = 1'h0;
      end

      // Overrun deliberately has no interrupt path
      next_st.irq = (next_st.rdy && next_st.drie)
                    || |(next_st.evs & next_st.eve);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st         <= '0;
         st.rx_byte <= wkr_pkg::RST_BYTE;
         st.id_lo   <= wkr_pkg::RST_BYTE;
         st.id_hi   <= wkr_pkg::RST_BYTE;
         st.azc     <= wkr_pkg::RST_AZC;
         st.evs     <= wkr_pkg::RST_EV;
         st.eve     <= wkr_pkg::RST_EV;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign dat_o     = st.dat;
   assign ack_o     = st.ack;
   assign irq_o     = st.irq;
   assign wake_o    = st.wake;
   assign az_seq_o  = st.azc[1:0];
   assign az_trim_o = st.azc[2];

   // ****************************************
   // Checks
   // ****************************************
   a_load_sets_ready: assert property (@(posedge clk_i) disable iff (rst_i)
      load |=> st.rdy && st.rx_byte == $past(asm_bus.byte_val))
      else $error("byte load did not set ready");

   a_overrun_unread: assert property (@(posedge clk_i) disable iff (rst_i)
      load && st.rdy && !rd_clr |=> st.ovf)
      else $error("overrun not flagged");

   a_write_rx_ignored: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wr && idx == wkr_pkg::IDX_RXB && !load |=> $stable(st.rx_byte)
      && $stable(st.rdy))
      else $error("write changed received byte");

   a_read_clears_ready: assert property (@(posedge clk_i)
      disable iff (rst_i)
      rd_clr && !load ##1 st.ack |-> !st.rdy
      && st.dat[7:0] == $past(st.rx_byte))
      else $error("read did not clear ready");

   a_load_needs_mode: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !st.dmode |=> $stable(st.rx_byte))
      else $error("byte loaded outside data mode");

   a_mismatch_drops: assert property (@(posedge clk_i)
      disable iff (rst_i)
      id_bad && !rx_msg_start_i |=> st.drop && !st.wake
      ##1 !st.wake)
      else $error("mismatched message woke the core");

   a_flag_clear_all: assert property (@(posedge clk_i)
      disable iff (rst_i)
      fclr && !load && !id_ok |=> !st.rdy && !st.ovf && !st.idf)
      else $error("flag clear strobe missed a flag");

   a_irq_follows_ready: assert property (@(posedge clk_i)
      disable iff (rst_i)
      st.rdy && st.drie |-> st.irq)
      else $error("interrupt missing while byte ready");

   a_page_one_guard: assert property (@(posedge clk_i)
      disable iff (rst_i)
      acc && st.page && pg_hit |=> $stable(st.id_lo)
      && $stable(st.id_hi) && st.dat == 32'h0000_0000)
      else $error("page one reached page-zero register");

   a_az_drives_pins: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wr && !st.page && idx == wkr_pkg::IDX_AZC |=>
      {az_trim_o, az_seq_o} == $past(dat_i[2:0]))
      else $error("autozero pins not updated");
endmodule : wkr_regs

/* File: testbench/wkr_lf_tx.sv */
// Purpose: LF transmitter model feeding decoded bits to the receiver
// Assumes: Bits change just after a rising clock edge
// Notes:   An idle bit line shows the inverse of the last bit sent
`timescale 1ns/1ps
module wkr_lf_tx (
   // Clock
   input  wire logic clk_i,
   // Decoded stream
   output logic      bit_o,
   output logic      bit_valid_o,
   output logic      msg_start_o
);
   initial begin
      bit_o       = 1'b0;
      bit_valid_o = 1'b0;
      msg_start_o = 1'b0;
   end

   // ****************************************
   // Frame tasks
   // ****************************************
   task automatic start_msg();
      @(posedge clk_i);
      msg_start_o <= 1'b1;
      @(posedge clk_i);
      msg_start_o <= 1'b0;
   endtask : start_msg

   // Gap 0 sends back to back, larger gaps stall between bits
   task automatic send_byte(input logic [7:0] b, input int gap);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_i);
         bit_o       <= b[i];
         bit_valid_o <= 1'b1;
         repeat (gap) begin
            @(posedge clk_i);
            bit_valid_o <= 1'b0;
            bit_o       <= ~b[i];
         end
      end
      @(posedge clk_i);
      bit_valid_o <= 1'b0;
      bit_o       <= ~b[0];
   endtask : send_byte
endmodule : wkr_lf_tx

/* File: testbench/wkr_regs_tb.sv */
// Purpose: Self-checking bench for the wakeup receiver register bank
// Assumes: One wait state slave, bits fed by the transmitter model
// Notes:   Status bit 4 is masked in the flags check, which compares only ready and overrun
`timescale 1ns/1ps
module wkr_regs_tb;
   logic        clk_i, rst_i, we, cyc, stb, ack, irq, wake, az_trim, ok;
   logic        rx_bit, rx_val, rx_start;
   logic [7:0]  adr, q, idh, idl;
   logic [31:0] dat_w, dat_r, seed;
   logic [1:0]  az_seq;
   int          error_cnt, samples_checked, wake_cnt;
   int          m_rx, m_rdy, m_ovf, m_wake;
   localparam logic [5:0] RST_IDX [5] = '{wkr_pkg::IDX_AZC,
      wkr_pkg::IDX_RXB, wkr_pkg::IDX_IDL, wkr_pkg::IDX_IDH, wkr_pkg::IDX_STAT};

   wkr_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
      .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_r),
      .ack_o(ack), .rx_bit_i(rx_bit), .rx_bit_valid_i(rx_val),
      .rx_msg_start_i(rx_start), .irq_o(irq), .wake_o(wake),
      .az_seq_o(az_seq), .az_trim_o(az_trim));
   wkr_lf_tx u_tx (.clk_i(clk_i), .bit_o(rx_bit), .bit_valid_o(rx_val),
      .msg_start_o(rx_start));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // Bus cycle held until ack is sampled, then released for a cycle
   task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= {idx, 2'b00};
      dat_w <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         $display("wrong value at %0t: no bus answer", $time);
         wrap_up();
      end
      @(posedge clk_i);
   endtask : wb

   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      check(q, exp, "register read");
   endtask : rdchk

   task automatic msg(input logic [7:0] hi, lo, d, input logic ld, idm);
      u_tx.start_msg();
      if (idm) begin
         u_tx.send_byte(hi, 0);
         u_tx.send_byte(lo, 1);
      end
      u_tx.send_byte(d, 2);
      repeat (3) @(posedge clk_i);
      if (ld) begin
         m_ovf  = m_ovf | m_rdy;
         m_rx   = d;
         m_rdy  = 1;
         m_wake = m_wake + 1;
      end
   endtask : msg

   // Checks interrupt, wake count and flags, then reads the byte, then clears all flags
   task automatic expect_state(input logic drie);
      check(irq, m_rdy[0] & drie, "irq with byte ready");
      check(8'(wake_cnt), 8'(m_wake), "wake count");
      wb(1'b0, wkr_pkg::IDX_STAT, 8'h00);
      check(q & 8'h88, {m_rdy[0], 3'b000, m_ovf[0], 3'b000}, "flags");
      rdchk(wkr_pkg::IDX_RXB, m_rx[7:0]);
      m_rdy = 0;
      check(irq, 1'b0, "irq after read");
      wb(1'b1, wkr_pkg::IDX_STAT, 8'h01);
      m_ovf = 0;
      rdchk(wkr_pkg::IDX_STAT, 8'h00);
   endtask : expect_state

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'h0000_1E12;
      error_cnt = 0;
      samples_checked = 0;
      wake_cnt = 0;
      m_rx = 0;
      m_rdy = 0;
      m_ovf = 0;
      m_wake = 0;
      {we, cyc, stb} = 3'b000;
      adr = 8'h00;
      dat_w = 32'h0000_0000;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (RST_IDX[i]) rdchk(RST_IDX[i], 8'h00);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, wkr_pkg::IDX_AZC, 8'(i));
         rdchk(wkr_pkg::IDX_AZC, 8'(i));
         check(8'(az_seq), 8'(i % 4), "autozero sequence");
         check(8'(az_trim), 8'(i / 4), "autozero trim");
      end
      idh = rnd();
      idl = rnd();
      wb(1'b1, wkr_pkg::IDX_IDH, idh);
      wb(1'b1, wkr_pkg::IDX_IDL, idl);
      rdchk(wkr_pkg::IDX_IDH, idh);
      rdchk(wkr_pkg::IDX_IDL, idl);
      msg(8'h00, 8'h00, rnd(), 1'b0, 1'b0);
      expect_state(1'b0);
      wb(1'b1, wkr_pkg::IDX_PCTL, 8'h18);
      msg(8'h00, 8'h00, rnd(), 1'b1, 1'b0);
      msg(8'h00, 8'h00, rnd(), 1'b1, 1'b0);
      wb(1'b1, wkr_pkg::IDX_PCTL, 8'h19);
      rdchk(wkr_pkg::IDX_RXB, 8'h00);
      wb(1'b1, wkr_pkg::IDX_STAT, 8'h01);
      wb(1'b1, wkr_pkg::IDX_IDL, ~idl);
      rdchk(wkr_pkg::IDX_IDL, 8'h00);
      wb(1'b1, wkr_pkg::IDX_PCTL, 8'h18);
      rdchk(wkr_pkg::IDX_IDL, idl);
      wb(1'b1, wkr_pkg::IDX_RXB, ~m_rx[7:0]);
      expect_state(1'b1);
      for (int m = 1; m < 4; m++) begin
         wb(1'b1, wkr_pkg::IDX_PCTL, {3'b000, 2'b11, 2'(m), 1'b0});
         for (int k = 0; k < 3; k++) begin
            ok = !((m % 2 == 1 && k == 1) || (m / 2 == 1 && k == 0));
            msg(k == 0 ? ~idh : idh, k == 1 ? ~idl : idl, rnd(), ok, 1'b1);
            expect_state(1'b1);
         end
      end
      // Event path: byte event alone raises irq while ready irq is off
      wb(1'b1, wkr_pkg::IDX_PCTL, 8'h08);
      wb(1'b1, wkr_pkg::IDX_EVC, 8'h07);
      wb(1'b1, wkr_pkg::IDX_EVE, 8'h01);
      rdchk(wkr_pkg::IDX_EVE, 8'h01);
      rdchk(wkr_pkg::IDX_EVS, 8'h00);
      check(irq, 1'b0, "irq with events cleared");
      msg(8'h00, 8'h00, rnd(), 1'b1, 1'b0);
      check(irq, 1'b1, "irq from byte event");
      rdchk(wkr_pkg::IDX_EVS, 8'h01);
      rdchk(wkr_pkg::IDX_EVC, 8'h00);
      wb(1'b1, wkr_pkg::IDX_EVC, 8'h01);
      expect_state(1'b0);
      wrap_up();
   end
endmodule : wkr_regs_tb
